// >>> pkg/acc_defines.svh
// Register offsets, field positions, reset values and encodings of the converter configuration block.
// Overview of operation
// - Index bits 1:0 one-hot select one core
// - Indexed write updates only one core
// - Core index resets to zero, none selected
// - Indexed read without valid core returns AD
// - Coarse and fine offset trims, 0x80 zero
// - Trims load from self-calibration results
// - Coarse gain four additive bits at 0x22
// - Medium and fine gain, 0x80 zero
// - Power field: pin, normal, nap, sleep
// - Register power per core, pin global
// - Power, divider, output mode survive soft reset
// - Skew trim 256 steps, resets to 80h
// - Bit0 write 0 then 1 slips clock when dividing by two
// - Divider field: pin, by one, by two
// - Driver field: pin, LVDS 2mA/3mA, LVCMOS
// - Coding field: pin, twos, Gray, binary
// - Status bit 6 selects DLL range
// - Test bits 7:6 static or alternate
// - Test bits 3:0 select output pattern
// - 0xC2 to 0xC5 hold user words
// - Pattern may appear some cycles late
// - Soft reset bit restores default registers
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
`define ACC_A_PORT_CFG 8'h00
`define ACC_A_INDEX 8'h10
`define ACC_A_OFF_C 8'h20
`define ACC_A_OFF_F 8'h21
`define ACC_A_GAIN_C 8'h22
`define ACC_A_GAIN_M 8'h23
`define ACC_A_GAIN_F 8'h24
`define ACC_A_POWER 8'h25
`define ACC_A_SKEW 8'h70
`define ACC_A_SLIP 8'h71
`define ACC_A_DIV 8'h72
`define ACC_A_DRIVER_SELECT_PIN 8'h73
`define ACC_A_DRIVER_SELECT_PIN_B 8'h74
`define ACC_A_STATUS 8'h75
`define ACC_A_TEST 8'hc0
`define ACC_A_W1_LO 8'hc2
`define ACC_A_W1_HI 8'hc3
`define ACC_A_W2_LO 8'hc4
`define ACC_A_W2_HI 8'hc5
`define ACC_SOFT_RST_BIT 5
`define ACC_DLL_BIT 6
`define ACC_ERR_BYTE 8'had
`define ACC_MID 8'h80
`define ACC_SKEW_RST 8'h80
`define ACC_ZERO8 8'h00
`define ACC_SEL0 2'h1
`define ACC_SEL1 2'h2
`define ACC_M_PIN 3'h0
`define ACC_M_A 3'h1
`define ACC_M_B 3'h2
`define ACC_M_C 3'h4
`define ACC_TM_STATIC 2'h0
`define ACC_TM_ALT 2'h1
`define ACC_P_OFF 4'h0
`define ACC_P_MID 4'h1
`define ACC_P_POS 4'h2
`define ACC_P_NEG 4'h3
`define ACC_P_CHECK 4'h4
`define ACC_P_ONEZERO 4'h7
`define ACC_P_USER 4'h8
`define ACC_W_MID 16'h8000
`define ACC_W_ONES 16'hffff
`define ACC_W_ZERO 16'h0000
`define ACC_W_CHK_A 16'haaaa
`define ACC_W_CHK_B 16'h5555
`define ACC_PIN_LOW 2'h0
`define ACC_PIN_FLOAT 2'h1
`endif

// >>> pkg/acc_pkg.sv
// Types shared by the converter configuration block.
package acc_pkg;
	// Trim words of one converter core.
	typedef struct packed {
		logic [7:0] off_coarse;
		logic [7:0] off_fine;
		logic [3:0] gain_coarse;
		logic [7:0] gain_medium;
		logic [7:0] gain_fine;
	} acc_trim_t;
	// Register access request from the serial port engine.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} acc_req_t;
	// Effective operating selections, each a one-hot code as in the registers.
	typedef struct packed {
		logic [2:0] driver;
		logic [2:0] coding;
		logic [2:0] divider;
	} acc_mode_t;
	// Phase slip sequencer states, Gray coded.
	typedef enum logic [1:0] {
		ACC_SLIP_IDLE = 2'b00,
		ACC_SLIP_ARMED = 2'b01
	} acc_slip_t;
endpackage

// >>> src/acc_config_regs.sv
// Configuration register file and mode decode of the dual-core interleaved converter.
`timescale 1ns/100ps
`include "acc_defines.svh"
module acc_config_regs
	import acc_pkg::*;
#(
	parameter int CORES = 2
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic resetn,
	// Register access from the serial port engine.
	input wire acc_req_t req,
	output logic [7:0] rdata,
	output logic rvalid,
	// Self-calibration results, one load strobe per core.
	input wire logic [CORES-1:0] cal_load,
	input wire acc_trim_t cal_trim,
	// Tri-level pins, coded low, float, high.
	input wire logic [1:0] power_state_pin,
	input wire logic [1:0] divider_pin,
	input wire logic [1:0] driver_select_pin,
	input wire logic [1:0] coding_select_pin,
	// Per-core controls and the shared skew trim.
	output acc_trim_t [CORES-1:0] core_trim,
	output logic [CORES-1:0][2:0] core_power,
	output logic [7:0] core_skew,
	// Global controls.
	output acc_mode_t mode,
	output logic [7:0] output_mode_b,
	output logic dll_slow,
	output logic clock_slip,
	// Test pattern.
	output logic test_enable,
	output logic [15:0] test_word
);
	logic [1:0] rst_sync;
	logic rst_n;
	logic wr;
	logic soft_rst;
	logic [1:0] index_reg;
	logic [CORES-1:0] sel;
	logic idx_valid;
	acc_trim_t trim_reg [CORES];
	acc_trim_t shadow_reg [CORES];
	logic [2:0] power_reg [CORES];
	logic [7:0] skew_reg;
	logic slip_bit_reg;
	acc_slip_t slip_state;
	logic [2:0] div_reg;
	logic [7:0] driver_select_pin_reg;
	logic [7:0] mode_b_reg;
	logic dll_reg;
	logic [7:0] test_ctrl_reg;
	logic [15:0] word1_reg;
	logic [15:0] word2_reg;
	logic phase_reg;
	logic [2:0] div_eff;
	logic [2:0] pin_power;
	logic [15:0] pat1;
	logic [15:0] pat2;
	logic [7:0] rd_next;
	acc_trim_t cur_trim;

	// Tri-level pin decode: low, float and high map to the three one-hot choices given.
	function automatic logic [2:0] tri_dec(input logic [1:0] pin, input logic [2:0] lo, input logic [2:0] fl,
		input logic [2:0] hi);
		if (pin == `ACC_PIN_LOW) begin
			return lo;
		end else if (pin == `ACC_PIN_FLOAT) begin
			return fl;
		end
		return hi;
	endfunction

	// One of the three defined one-hot codes or the pin-control code.
	function automatic logic legal_code(input logic [2:0] v);
		return (v == `ACC_M_PIN) || (v == `ACC_M_A) || (v == `ACC_M_B) || (v == `ACC_M_C);
	endfunction

	// Reset release through two flip-flops.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// Write strobe and soft reset request.
	assign wr = req.wr;
	assign soft_rst = wr && (req.addr == `ACC_A_PORT_CFG) && req.wdata[`ACC_SOFT_RST_BIT];
	assign idx_valid = (index_reg == `ACC_SEL0) || (index_reg == `ACC_SEL1);
	assign sel = idx_valid ? index_reg : 2'b00;

	// Core index register.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			index_reg <= 2'b00;
		end else if (soft_rst) begin
			index_reg <= 2'b00;
		end else if (wr && req.addr == `ACC_A_INDEX) begin
			index_reg <= req.wdata[1:0];
		end
	end

	// Per-core trims, calibration shadow and power override.
	for (genvar c = 0; c < CORES; c++) begin : g_core
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				shadow_reg[c] <= '{`ACC_MID, `ACC_MID, 4'h0, `ACC_MID, `ACC_MID};
			end else if (cal_load[c]) begin
				shadow_reg[c] <= cal_trim;
			end
		end
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				trim_reg[c] <= '{`ACC_MID, `ACC_MID, 4'h0, `ACC_MID, `ACC_MID};
			end else if (cal_load[c]) begin
				trim_reg[c] <= cal_trim;
			end else if (soft_rst) begin
				trim_reg[c] <= shadow_reg[c];
			end else if (wr && sel[c]) begin
				case (req.addr)
					`ACC_A_OFF_C: trim_reg[c].off_coarse <= req.wdata;
					`ACC_A_OFF_F: trim_reg[c].off_fine <= req.wdata;
					`ACC_A_GAIN_C: trim_reg[c].gain_coarse <= req.wdata[3:0];
					`ACC_A_GAIN_M: trim_reg[c].gain_medium <= req.wdata;
					`ACC_A_GAIN_F: trim_reg[c].gain_fine <= req.wdata;
					default: trim_reg[c] <= trim_reg[c];
				endcase
			end
		end
		// Power override ignores soft reset and reserved codes.
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				power_reg[c] <= `ACC_M_PIN;
			end else if (wr && sel[c] && req.addr == `ACC_A_POWER && legal_code(req.wdata[2:0])) begin
				power_reg[c] <= req.wdata[2:0];
			end
		end
		// Effective power state: register per core, or the pin for all cores.
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				core_power[c] <= `ACC_M_A;
				core_trim[c] <= '{`ACC_MID, `ACC_MID, 4'h0, `ACC_MID, `ACC_MID};
			end else begin
				core_power[c] <= (power_reg[c] == `ACC_M_PIN) ? pin_power : power_reg[c];
				core_trim[c] <= trim_reg[c];
			end
		end
	end

	assign pin_power = tri_dec(power_state_pin, `ACC_M_A, `ACC_M_B, `ACC_M_C);

	// Skew trim, reset by power-up and by soft reset.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			skew_reg <= `ACC_SKEW_RST;
		end else if (soft_rst) begin
			skew_reg <= `ACC_SKEW_RST;
		end else if (wr && req.addr == `ACC_A_SKEW) begin
			skew_reg <= req.wdata;
		end
	end

	// Divider and output mode overrides survive soft reset; reserved codes are ignored.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= `ACC_M_PIN;
		end else if (wr && req.addr == `ACC_A_DIV && legal_code(req.wdata[2:0]) && req.wdata[2:0] != `ACC_M_C) begin
			div_reg <= req.wdata[2:0];
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			driver_select_pin_reg <= `ACC_ZERO8;
		end else if (wr && req.addr == `ACC_A_DRIVER_SELECT_PIN) begin
			if (legal_code(req.wdata[7:5])) begin
				driver_select_pin_reg[7:5] <= req.wdata[7:5];
			end
			if (legal_code(req.wdata[2:0])) begin
				driver_select_pin_reg[2:0] <= req.wdata[2:0];
			end
		end
	end

	// Second output mode and DLL range; the host applies its XOR procedure before writing.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode_b_reg <= `ACC_ZERO8;
			dll_reg <= 1'b0;
		end else if (soft_rst) begin
			mode_b_reg <= `ACC_ZERO8;
			dll_reg <= 1'b0;
		end else if (wr && req.addr == `ACC_A_DRIVER_SELECT_PIN_B) begin
			mode_b_reg <= req.wdata;
		end else if (wr && req.addr == `ACC_A_STATUS) begin
			dll_reg <= req.wdata[`ACC_DLL_BIT];
		end
	end

	assign div_eff = (div_reg == `ACC_M_PIN) ? tri_dec(divider_pin, `ACC_M_A, `ACC_M_B, `ACC_M_B) : div_reg;

	// Phase slip: a write of 0 then a write of 1 to bit 0 advances the divided clock when dividing by two.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			slip_state <= ACC_SLIP_IDLE;
			slip_bit_reg <= 1'b0;
			clock_slip <= 1'b0;
		end else begin
			clock_slip <= 1'b0;
			if (wr && req.addr == `ACC_A_SLIP) begin
				slip_bit_reg <= req.wdata[0];
				case (slip_state)
					ACC_SLIP_IDLE: begin
						if (!req.wdata[0]) begin
							slip_state <= ACC_SLIP_ARMED;
						end
					end
					ACC_SLIP_ARMED: begin
						if (req.wdata[0]) begin
							slip_state <= ACC_SLIP_IDLE;
							clock_slip <= (div_eff == `ACC_M_B);
						end
					end
					default: slip_state <= ACC_SLIP_IDLE;
				endcase
			end
		end
	end

	// Test control and user words.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			test_ctrl_reg <= `ACC_ZERO8;
			word1_reg <= 16'h0000;
			word2_reg <= 16'h0000;
		end else if (soft_rst) begin
			test_ctrl_reg <= `ACC_ZERO8;
			word1_reg <= 16'h0000;
			word2_reg <= 16'h0000;
		end else if (wr) begin
			case (req.addr)
				`ACC_A_TEST: begin
					if (req.wdata[7] == 1'b0) begin
						test_ctrl_reg[7:6] <= req.wdata[7:6];
					end
					if (req.wdata[3:0] <= `ACC_P_USER && req.wdata[3:0] != 4'h5 && req.wdata[3:0] != 4'h6) begin
						test_ctrl_reg[3:0] <= req.wdata[3:0];
					end
				end
				`ACC_A_W1_LO: word1_reg[7:0] <= req.wdata;
				`ACC_A_W1_HI: word1_reg[15:8] <= req.wdata;
				`ACC_A_W2_LO: word2_reg[7:0] <= req.wdata;
				`ACC_A_W2_HI: word2_reg[15:8] <= req.wdata;
				default: test_ctrl_reg <= test_ctrl_reg;
			endcase
		end
	end

	// Pattern words for the selected test pattern.
	always_comb begin
		pat1 = `ACC_W_ZERO;
		pat2 = `ACC_W_ZERO;
		case (test_ctrl_reg[3:0])
			`ACC_P_MID: begin
				pat1 = `ACC_W_MID;
				pat2 = `ACC_W_MID;
			end
			`ACC_P_POS: begin
				pat1 = `ACC_W_ONES;
				pat2 = `ACC_W_ONES;
			end
			`ACC_P_CHECK: begin
				pat1 = `ACC_W_CHK_A;
				pat2 = `ACC_W_CHK_B;
			end
			`ACC_P_ONEZERO: begin
				pat1 = `ACC_W_ONES;
				pat2 = `ACC_W_ZERO;
			end
			`ACC_P_USER: begin
				pat1 = word1_reg;
				pat2 = word2_reg;
			end
			default: begin
				pat1 = `ACC_W_ZERO;
				pat2 = `ACC_W_ZERO;
			end
		endcase
	end

	// Test output: word 1 when static, alternating words on successive clocks when alternate.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= 1'b0;
			test_enable <= 1'b0;
			test_word <= 16'h0000;
		end else begin
			phase_reg <= (test_ctrl_reg[7:6] == `ACC_TM_ALT) ? !phase_reg : 1'b0;
			test_enable <= (test_ctrl_reg[3:0] != `ACC_P_OFF);
			test_word <= phase_reg ? pat2 : pat1;
		end
	end

	// Global control outputs, registered.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= '{`ACC_M_A, `ACC_M_A, `ACC_M_A};
			core_skew <= `ACC_SKEW_RST;
			output_mode_b <= `ACC_ZERO8;
			dll_slow <= 1'b0;
		end else begin
			mode.driver <= (driver_select_pin_reg[7:5] == `ACC_M_PIN) ?
				tri_dec(driver_select_pin, `ACC_M_A, `ACC_M_B, `ACC_M_C) : driver_select_pin_reg[7:5];
			mode.coding <= (driver_select_pin_reg[2:0] == `ACC_M_PIN) ?
				tri_dec(coding_select_pin, `ACC_M_C, `ACC_M_A, `ACC_M_B) : driver_select_pin_reg[2:0];
			mode.divider <= div_eff;
			core_skew <= skew_reg;
			output_mode_b <= mode_b_reg;
			dll_slow <= dll_reg;
		end
	end

	// Read multiplexer; indexed registers answer the error byte without a valid core.
	always_comb begin
		cur_trim = (index_reg == `ACC_SEL1) ? trim_reg[1] : trim_reg[0];
		rd_next = `ACC_ZERO8;
		case (req.addr)
			`ACC_A_INDEX: rd_next = {6'h00, index_reg};
			`ACC_A_OFF_C: rd_next = idx_valid ? cur_trim.off_coarse : `ACC_ERR_BYTE;
			`ACC_A_OFF_F: rd_next = idx_valid ? cur_trim.off_fine : `ACC_ERR_BYTE;
			`ACC_A_GAIN_C: rd_next = idx_valid ? {4'h0, cur_trim.gain_coarse} : `ACC_ERR_BYTE;
			`ACC_A_GAIN_M: rd_next = idx_valid ? cur_trim.gain_medium : `ACC_ERR_BYTE;
			`ACC_A_GAIN_F: rd_next = idx_valid ? cur_trim.gain_fine : `ACC_ERR_BYTE;
			`ACC_A_POWER: rd_next = idx_valid ? {5'h00, (index_reg == `ACC_SEL1) ? power_reg[1] : power_reg[0]} :
				`ACC_ERR_BYTE;
			`ACC_A_SKEW: rd_next = skew_reg;
			`ACC_A_SLIP: rd_next = {7'h00, slip_bit_reg};
			`ACC_A_DIV: rd_next = {5'h00, div_reg};
			`ACC_A_DRIVER_SELECT_PIN: rd_next = driver_select_pin_reg;
			`ACC_A_DRIVER_SELECT_PIN_B: rd_next = mode_b_reg;
			`ACC_A_STATUS: rd_next = {1'b0, dll_reg, 6'h00};
			`ACC_A_TEST: rd_next = test_ctrl_reg;
			`ACC_A_W1_LO: rd_next = word1_reg[7:0];
			`ACC_A_W1_HI: rd_next = word1_reg[15:8];
			`ACC_A_W2_LO: rd_next = word2_reg[7:0];
			`ACC_A_W2_HI: rd_next = word2_reg[15:8];
			default: rd_next = `ACC_ZERO8;
		endcase
	end

	// Read answer one clock after the request.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= `ACC_ZERO8;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd;
			rdata <= req.rd ? rd_next : rdata;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_arm;
		wr && req.addr == `ACC_A_SLIP && !req.wdata[0];
	endsequence
	sequence s_fire;
		wr && req.addr == `ACC_A_SLIP && req.wdata[0] && div_eff == `ACC_M_B;
	endsequence
	// One cycle with no phase slip write between the two halves of the command.
	sequence s_gap;
		!(wr && req.addr == `ACC_A_SLIP);
	endsequence

	AST_INDEX_SOFT_RESET: assert property (soft_rst |=> index_reg == 2'b00)
		else $error("index not cleared by soft reset");
	AST_ERR_READ: assert property (req.rd && !idx_valid && req.addr >= `ACC_A_OFF_C && req.addr <= `ACC_A_POWER
		|=> rvalid && rdata == `ACC_ERR_BYTE)
		else $error("indexed read without core did not return error byte");
	AST_ONE_CORE: assert property (wr && req.addr == `ACC_A_OFF_C && !cal_load[1] && !soft_rst && index_reg == `ACC_SEL0
		|=> trim_reg[1] == $past(trim_reg[1]))
		else $error("unselected core trim changed");
	AST_SLIP: assert property (s_arm ##1 s_gap ##1 s_fire |=> clock_slip)
		else $error("phase slip not issued");
	AST_NO_SLIP: assert property (clock_slip |-> $past(div_eff) == `ACC_M_B)
		else $error("phase slip outside divide by two");
	AST_POWER_KEEP: assert property (soft_rst |=> power_reg[0] == $past(power_reg[0]) && div_reg == $past(div_reg))
		else $error("soft reset changed exempt register");
	AST_SKEW_DEFAULT: assert property (soft_rst |=> skew_reg == `ACC_SKEW_RST ##1 core_skew == `ACC_SKEW_RST)
		else $error("skew trim not restored");
	AST_DIV_RESERVED: assert property (wr && req.addr == `ACC_A_DIV && req.wdata[2:0] == `ACC_M_C |=> $stable(div_reg))
		else $error("forbidden divider code accepted");
	AST_ALT_TOGGLE: assert property (test_ctrl_reg[7:6] == `ACC_TM_ALT [*3] |-> phase_reg != $past(phase_reg))
		else $error("alternate test phase stuck");
	AST_PIN_POWER: assert property (power_reg[0] == `ACC_M_PIN && $stable(power_state_pin)
		|=> core_power[0] == $past(pin_power))
		else $error("pin power not applied");
endmodule

// >>> test/acc_host_model.sv
// Serial host model that issues register reads and writes to the configuration block.
`timescale 1ns/100ps
module acc_host_model
	import acc_pkg::*;
(
	// Clock.
	input wire logic mclk,
	// Register access and its answer.
	output acc_req_t req,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	// The port is idle from time zero.
	initial begin
		req = '{wr: 1'b0, rd: 1'b0, addr: 8'hff, wdata: 8'hff};
	end
	// One write, held for a single taking edge; released address and data are inverted.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge mclk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// One read; the answer is taken while rvalid stands, within a bounded wait.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n = 0;
		d = 8'hxx;
		@(negedge mclk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge mclk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
		repeat (4) begin
			if (rvalid === 1'b1 && n == 0) begin
				d = rdata;
				n = 1;
			end
			@(negedge mclk);
		end
	endtask
	// Divided clock advance: bit 0 written low, then high.
	task automatic slip();
		wr(8'h71, 8'h00);
		wr(8'h71, 8'h01);
	endtask
	// The second output mode register is set through the read, XOR, XOR, write sequence.
	task automatic set_mode_b(input logic [7:0] want, output logic [7:0] sent);
		logic [7:0] b;
		logic [7:0] s;
		rd(8'h74, b);
		rd(8'h75, s);
		sent = b ^ s ^ want;
		wr(8'h74, sent);
	endtask
endmodule

// >>> test/adc_core_config_registers_test.sv
// Self-checking testbench of the converter configuration register block.
`timescale 1ns/100ps
module adc_core_config_registers_test
	import acc_pkg::*;
;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	acc_req_t req;
	logic [7:0] rdata;
	logic rvalid;
	logic [1:0] cal_load = 2'b00;
	acc_trim_t cal_trim = '0;
	logic [1:0] power_state_pin = 2'h1;
	logic [1:0] divider_pin = 2'h0;
	logic [1:0] driver_select_pin = 2'h2;
	logic [1:0] coding_select_pin = 2'h0;
	acc_trim_t [1:0] core_trim;
	logic [1:0][2:0] core_power;
	logic [7:0] core_skew;
	acc_mode_t mode;
	logic [7:0] output_mode_b;
	logic dll_slow;
	logic clock_slip;
	logic test_enable;
	logic [15:0] test_word;
	int err_total = 0;
	int tests_run = 0;
	int slip_cnt = 0;
	int n0;
	logic [7:0] got;
	logic [7:0] sent;
	logic [2:0] oh;
	logic [15:0] s0;
	logic [15:0] s1;
	logic [15:0] e0;
	logic [3:0] pat [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8};
	logic [15:0] w1s [6] = '{16'h8000, 16'hffff, 16'h0000, 16'haaaa, 16'hffff, 16'h1234};
	logic [15:0] w2s [6] = '{16'h8000, 16'hffff, 16'h0000, 16'h5555, 16'h0000, 16'habcd};

	// Clock at 40 MHz.
	always #12.5 mclk = ~mclk;

	// Counts divided clock advance pulses.
	always @(posedge mclk) begin
		slip_cnt <= slip_cnt + int'(clock_slip === 1'b1);
	end

	acc_config_regs #(.CORES(2)) i_dut (.mclk(mclk), .resetn(resetn), .req(req), .rdata(rdata), .rvalid(rvalid),
		.cal_load(cal_load), .cal_trim(cal_trim), .power_state_pin(power_state_pin), .divider_pin(divider_pin),
		.driver_select_pin(driver_select_pin), .coding_select_pin(coding_select_pin), .core_trim(core_trim),
		.core_power(core_power), .core_skew(core_skew), .mode(mode), .output_mode_b(output_mode_b),
		.dll_slow(dll_slow), .clock_slip(clock_slip), .test_enable(test_enable), .test_word(test_word));

	acc_host_model i_host (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid));

	// Compares a port value.
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Reads a register and compares it.
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		i_host.rd(a, got);
		chk($sformatf("register %h", a), {8'h00, exp}, {8'h00, got});
	endtask
	// Lets written values reach the outputs.
	task automatic settle();
		repeat (3) @(negedge mclk);
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Cuts a hang short.
	initial begin
		repeat (4000) @(posedge mclk);
		err_total++;
		summarize();
	end

	// Test sequence.
	initial begin
		repeat (8) @(negedge mclk);
		resetn = 1'b1;
		repeat (4) @(negedge mclk);
		rd_chk(8'h10, 8'h00);
		rd_chk(8'h70, 8'h80);
		rd_chk(8'h20, 8'had);
		rd_chk(8'h75, 8'h00);
		chk("pin modes", {7'h0, 3'b100, 3'b100, 3'b001}, {7'h0, mode});
		chk("pin power", 16'h0012, {10'h0, core_power});
		i_host.wr(8'h70, 8'h05);
		settle();
		chk("skew", 16'h0005, {8'h0, core_skew});
		$display("test reset done");
		i_host.wr(8'h20, 8'h55);
		i_host.wr(8'h10, 8'h01);
		rd_chk(8'h20, 8'h80);
		i_host.wr(8'h20, 8'h12);
		i_host.wr(8'h10, 8'h02);
		i_host.wr(8'h20, 8'h34);
		i_host.wr(8'h22, 8'h0c);
		i_host.wr(8'h23, 8'hff);
		settle();
		chk("core0 offset", 16'h0012, {8'h0, core_trim[0].off_coarse});
		chk("core1 offset", 16'h0034, {8'h0, core_trim[1].off_coarse});
		chk("core1 gain", 16'h000c, {12'h0, core_trim[1].gain_coarse});
		chk("core0 medium", 16'h0080, {8'h0, core_trim[0].gain_medium});
		rd_chk(8'h23, 8'hff);
		i_host.wr(8'h10, 8'h03);
		rd_chk(8'h21, 8'had);
		cal_trim <= '{off_coarse: 8'h11, off_fine: 8'h22, gain_coarse: 4'h3, gain_medium: 8'h44, gain_fine: 8'h55};
		cal_load <= 2'b01;
		@(negedge mclk);
		cal_load <= 2'b00;
		settle();
		chk("core0 cal", 16'h0055, {8'h0, core_trim[0].gain_fine});
		chk("core1 kept", 16'h0034, {8'h0, core_trim[1].off_coarse});
		$display("test trims done");
		i_host.wr(8'h10, 8'h01);
		i_host.wr(8'h25, 8'h04);
		i_host.wr(8'h25, 8'h03);
		settle();
		chk("power sleep", 16'h0014, {10'h0, core_power});
		power_state_pin <= 2'h2;
		i_host.wr(8'h25, 8'h01);
		settle();
		chk("power normal", 16'h0021, {10'h0, core_power});
		i_host.wr(8'h25, 8'h02);
		settle();
		chk("power nap", 16'h0022, {10'h0, core_power});
		$display("test power done");
		n0 = slip_cnt;
		i_host.slip();
		settle();
		chk("no slip by one", 16'h0, 16'(slip_cnt - n0));
		i_host.wr(8'h72, 8'h02);
		i_host.wr(8'h72, 8'h04);
		settle();
		chk("divider", 16'h0002, {13'h0, mode.divider});
		n0 = slip_cnt;
		i_host.slip();
		i_host.wr(8'h71, 8'h01);
		settle();
		chk("one slip", 16'h1, 16'(slip_cnt - n0));
		$display("test clock done");
		for (int i = 0; i < 3; i++) begin
			oh = 3'b001 << i;
			i_host.wr(8'h73, {oh, 2'b00, {oh[0], oh[1], oh[2]}});
			settle();
			chk("driver", {13'h0, oh}, {13'h0, mode.driver});
			chk("coding", {13'h0, oh[0], oh[1], oh[2]}, {13'h0, mode.coding});
		end
		i_host.wr(8'h73, 8'h63);
		settle();
		chk("modes kept", 16'h0021, {10'h0, mode.driver, mode.coding});
		i_host.wr(8'h75, 8'h40);
		i_host.set_mode_b(8'h5a, sent);
		settle();
		chk("dll slow", 16'h1, {15'h0, dll_slow});
		chk("mode b", {8'h0, 8'h5a ^ 8'h40}, {8'h0, output_mode_b});
		$display("test output modes done");
		i_host.wr(8'hc2, 8'h34);
		i_host.wr(8'hc3, 8'h12);
		i_host.wr(8'hc4, 8'hcd);
		i_host.wr(8'hc5, 8'hab);
		for (int i = 0; i < 6; i++) begin
			i_host.wr(8'hc0, {4'h4, pat[i]});
			repeat (4) @(negedge mclk);
			s0 = test_word;
			@(negedge mclk);
			s1 = test_word;
			e0 = (s0 === w2s[i]) ? w2s[i] : w1s[i];
			chk("pattern first", e0, s0);
			chk("pattern second", (e0 === w1s[i]) ? w2s[i] : w1s[i], s1);
		end
		i_host.wr(8'hc0, 8'h08);
		i_host.wr(8'hc0, 8'h05);
		repeat (4) @(negedge mclk);
		s0 = test_word;
		@(negedge mclk);
		chk("static first", 16'h1234, s0);
		chk("static second", 16'h1234, test_word);
		chk("pattern on", 16'h1, {15'h0, test_enable});
		i_host.wr(8'hc0, 8'h00);
		settle();
		chk("pattern off", 16'h0, {15'h0, test_enable});
		$display("test patterns done");
		i_host.wr(8'hc0, 8'h48);
		i_host.wr(8'h00, 8'h20);
		settle();
		rd_chk(8'h10, 8'h00);
		rd_chk(8'h70, 8'h80);
		rd_chk(8'hc2, 8'h00);
		rd_chk(8'h72, 8'h02);
		rd_chk(8'h73, 8'h81);
		chk("power kept", 16'h0022, {10'h0, core_power});
		chk("trim shadow", 16'h0011, {8'h0, core_trim[0].off_coarse});
		chk("test cleared", 16'h0, {15'h0, test_enable});
		$display("test soft reset done");
		driver_select_pin <= 2'h1;
		coding_select_pin <= 2'h2;
		divider_pin <= 2'h3;
		i_host.wr(8'h72, 8'h00);
		i_host.wr(8'h73, 8'h00);
		settle();
		chk("pin modes late", {7'h0, 3'b010, 3'b010, 3'b010}, {7'h0, mode});
		$display("test pin control done");
		summarize();
	end
endmodule
